// ---- can_comms_diagnostic_status_bench.sv ----
// Self-checking bench for the CAN diagnostic block
`timescale 1ns/1ps
`include "ccds_consts.svh"
module can_comms_diagnostic_status_bench;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, rx_byte_valid, rx_byte_read, tx_request, tx_buf_full;
   logic rx_msg_valid, rx_header_ok, rx_len_bad, rx_checksum_bad, rx_decode_bad;
   logic rx_id_bad, rx_sample_count_bad, cfg_overlap, cfg_mismatch, cfg_resent;
   logic bus_err, ctrl_tx_warn, remote_status_valid, can_enable, resume;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] remote_status, reason, evv;
   logic [`CCDS_DIAG_W-1:0] diag_word_q;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int fails = 0, samples_checked = 0, cycles = 0, seed;
   logic [51:0] tbl [18] = '{52'h1_0030_0000_0008, 52'h1_0020_0000_0000,
      52'h1_0002_0000_0000, 52'h1_0002_0000_0008, 52'h1_0001_0000_0000,
      52'h1_0002_0000_0000, 52'h1_000C_0000_4100, 52'h1_1A00_0000_0400,
      52'h2_1A00_0000_0000, 52'h1_1900_0000_0800, 52'h2_1880_0000_0800,
      52'h2_1C00_0000_0002, 52'h4_1840_0000_0002, 52'h4_1C00_0000_0800,
      52'h4_4000_0000_0100, 52'h4_0000_0000_0100, 52'h4_2000_FFFF_FFFF,
      52'h4_0000_0000_0000};
   assign {cfg_mismatch, cfg_resent, rx_msg_valid, rx_header_ok, rx_len_bad, rx_checksum_bad,
      rx_decode_bad, rx_id_bad, rx_sample_count_bad, tx_request, tx_buf_full, cfg_overlap,
      ctrl_tx_warn, rx_byte_valid, rx_byte_read} = evv[14:0];
   ccds_diag #(.NODATA_CYCLES(60000)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_byte_valid, .rx_byte_read,
      .tx_request, .tx_buf_full, .rx_msg_valid, .rx_header_ok, .rx_len_bad, .rx_checksum_bad,
      .rx_decode_bad, .rx_id_bad, .rx_sample_count_bad, .cfg_overlap, .cfg_mismatch,
      .cfg_resent, .bus_err, .ctrl_tx_warn, .remote_status_valid, .remote_status,
      .can_enable, .diag_word_q);
   ccds_remote_node i_node (.aclk, .resume, .reason, .remote_status_valid, .remote_status);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic give_verdict();
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         give_verdict();
      end
   end
   task automatic cmp_rd(input logic [33:0] e);
      samples_checked++;
      if ({s_axi_rresp, s_axi_rdata} !== e) begin
         fails++;
         $display("[FAIL] read exp %h got %h", e, {s_axi_rresp, s_axi_rdata});
      end
   endtask : cmp_rd
   task automatic cmp_wr(input logic [1:0] e);
      samples_checked++;
      if (s_axi_bresp !== e) begin
         fails++;
         $display("[FAIL] bresp exp %h got %h", e, s_axi_bresp);
      end
   endtask : cmp_wr
   always @(posedge aclk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) cmp_rd(rq.pop_front());
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) cmp_wr(bq.pop_front());
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ad, wd;
      bq.push_back(r);
      ad = 1'b0;
      wd = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         ad = ad | s_axi_awready;
         wd = wd | s_axi_wready;
         if (ad) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (wd) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      rq.push_back({r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   task automatic ev(input logic [51:0] t);
      wr(`CCDS_A_CFG, {28'h000_0000, t[51:48]}, 2'h0);
      wr(`CCDS_A_CLEAR, 32'h0000_FFFF, 2'h0);
      evv <= t[47:32];
      @(posedge aclk);
      evv <= 16'h0000;
      if (t[31:0] !== 32'hFFFF_FFFF) rd(`CCDS_A_DIAG, t[31:0], 2'h0);
   endtask : ev
   task automatic errs(input int n);
      repeat (n) begin
         bus_err <= 1'b1;
         @(posedge aclk);
         bus_err <= 1'b0;
         @(posedge aclk);
      end
      wr(`CCDS_A_CLEAR, 32'h0000_FFFF, 2'h0);
   endtask : errs
   initial begin
      seed = 16793;
      aresetn = 1'b0;
      s_axi_wstrb = 4'hF;
      evv = 16'h0000;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {bus_err, resume, s_axi_awaddr, s_axi_araddr, s_axi_wdata, reason} = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`CCDS_A_DIAG, 32'h0000_0000, 2'h0);
      rd(`CCDS_A_CTRL, 32'h0000_0001, 2'h0);
      wr(12'h020, $random(seed), 2'h2);
      rd(12'h020, 32'h0000_0000, 2'h2);
      $display("test reset done");
      for (int i = 0; i < 18; i++) ev(tbl[i]);
      $display("test events done");
      for (int i = 0; i < 6; i++) begin
         reason <= `CCDS_ST_RESTART + 16'(i);
         resume <= 1'b1;
         @(posedge aclk);
         resume <= 1'b0;
         repeat (2) @(posedge aclk);
         rd(`CCDS_A_STATUS, {16'h0001, `CCDS_ST_RESTART + 16'(i)}, 2'h0);
         rd(`CCDS_A_STATUS, {16'h0000, `CCDS_ST_RESTART + 16'(i)}, 2'h0);
      end
      $display("test status done");
      wr(`CCDS_A_CFG, 32'h0000_0001, 2'h0);
      errs(96);
      rd(`CCDS_A_ERRCNT, 32'h0000_0060, 2'h0);
      rd(`CCDS_A_DIAG, 32'h0000_0000, 2'h0);
      errs(1);
      rd(`CCDS_A_DIAG, 32'h0000_1000, 2'h0);
      rd(`CCDS_A_CTRL, 32'h0000_0001, 2'h0);
      errs(159);
      rd(`CCDS_A_DIAG, 32'h0000_3000, 2'h0);
      rd(`CCDS_A_CTRL, 32'h0000_0000, 2'h0);
      wr(`CCDS_A_CTRL, 32'h0000_0002, 2'h0);
      wr(`CCDS_A_CLEAR, 32'h0000_FFFF, 2'h0);
      rd(`CCDS_A_CTRL, 32'h0000_0001, 2'h0);
      rd(`CCDS_A_ERRCNT, 32'h0000_0000, 2'h0);
      $display("test bus errors done");
      s_axi_wstrb <= 4'hE;
      wr(`CCDS_A_WNDW, 32'h0000_0014, 2'h0);
      rd(`CCDS_A_WNDW, 32'h0000_0000, 2'h0);
      s_axi_wstrb <= 4'hF;
      wr(`CCDS_A_WNDW, 32'h0000_0014, 2'h0);
      repeat (40) @(posedge aclk);
      rd(`CCDS_A_DIAG, 32'h0000_0200, 2'h0);
      $display("test no data done");
      give_verdict();
   end
endmodule : can_comms_diagnostic_status_bench

// ---- ccds_consts.svh ----
// Constants for the CAN communications diagnostic block
`ifndef CCDS_CONSTS_SVH
`define CCDS_CONSTS_SVH
`define CCDS_DIAG_W 16
`define CCDS_B_FRAMING 1
`define CCDS_B_OVERRUN 3
`define CCDS_B_BADCFG 8
`define CCDS_B_NODATA 9
`define CCDS_B_CHECKSUM 10
`define CCDS_B_WRONG 11
`define CCDS_B_WARN 12
`define CCDS_B_BUSOFF 13
`define CCDS_B_TXWARN 14
`define CCDS_WARN_LIMIT 9'h060
`define CCDS_OFF_LIMIT 9'h0FF
`define CCDS_ST_RESTART 16'h1001
`define CCDS_ST_HALT 16'h1002
`define CCDS_ST_OVERRUN 16'h1003
`define CCDS_ST_SYNC_TO 16'h1004
`define CCDS_ST_CAN_ERR 16'h1005
`define CCDS_ST_SYNC_EX 16'h1006
`define CCDS_A_DIAG 12'h000
`define CCDS_A_CLEAR 12'h004
`define CCDS_A_CTRL 12'h008
`define CCDS_A_ERRCNT 12'h00C
`define CCDS_A_STATUS 12'h010
`define CCDS_A_CFG 12'h014
`define CCDS_A_WNDW 12'h018
`define CCDS_NODATA_DEF 32'h0001_0000
`define CCDS_RESP_OK 2'h0
`define CCDS_RESP_ERR 2'h2
`endif

// ---- ccds_diag.sv ----
// CAN communications diagnostic word with AXI4-Lite register access
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ccds_consts.svh"
module ccds_diag #(
   parameter int NODATA_CYCLES = `CCDS_NODATA_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_byte_valid,
   input wire logic rx_byte_read,
   input wire logic tx_request,
   input wire logic tx_buf_full,
   input wire logic rx_msg_valid,
   input wire logic rx_header_ok,
   input wire logic rx_len_bad,
   input wire logic rx_checksum_bad,
   input wire logic rx_decode_bad,
   input wire logic rx_id_bad,
   input wire logic rx_sample_count_bad,
   input wire logic cfg_overlap,
   input wire logic cfg_mismatch,
   input wire logic cfg_resent,
   input wire logic bus_err,
   input wire logic ctrl_tx_warn,
   input wire logic remote_status_valid,
   input wire logic [15:0] remote_status,
   output logic can_enable,
   output logic [`CCDS_DIAG_W-1:0] diag_word_q
);
   ccds_pkg::ccds_mode_t mode_q;
   ccds_pkg::ccds_bus_t bus_q;
   logic [`CCDS_DIAG_W-1:0] sticky_q;
   logic [`CCDS_DIAG_W-1:0] clr_mask;
   logic [`CCDS_DIAG_W-1:0] ev;
   logic [8:0] err_cnt;
   logic warn;
   logic bus_off;
   logic recover;
   logic rx_pending_q;
   logic mismatch_q;
   logic [31:0] idle_cnt_q;
   logic [31:0] nodata_limit_q;
   logic nodata;
   logic [15:0] last_status_q;
   logic status_new_q;
   logic [11:0] aw_addr_q;
   logic aw_have_q;
   logic [31:0] w_data_q;
   logic w_have_q;
   logic wr_fire;
   logic [31:0] rd_val;
   logic rd_ok;

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == `CCDS_A_DIAG) || (a == `CCDS_A_CLEAR) || (a == `CCDS_A_CTRL)
         || (a == `CCDS_A_ERRCNT) || (a == `CCDS_A_STATUS) || (a == `CCDS_A_CFG)
         || (a == `CCDS_A_WNDW);
   endfunction : mapped

   function automatic logic is_mode(input ccds_pkg::ccds_mode_t m,
                                    input ccds_pkg::ccds_mode_t want);
      is_mode = (m == want);
   endfunction : is_mode

   ccds_err_counter #(.CNT_W(9)) u_cnt (
      .aclk(aclk),
      .aresetn(aresetn),
      .bus_err(bus_err),
      .recover(recover),
      .count_q(err_cnt),
      .warn(warn),
      .bus_off(bus_off)
   );

   // Bus state; communication suspended while off
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_q <= ccds_pkg::CCDS_BUS_ACTIVE;
      end else begin
         case (bus_q)
            ccds_pkg::CCDS_BUS_ACTIVE: begin
               if (bus_off) begin
                  bus_q <= ccds_pkg::CCDS_BUS_OFF;
               end
            end
            ccds_pkg::CCDS_BUS_OFF: begin
               if (recover) begin
                  bus_q <= ccds_pkg::CCDS_BUS_ACTIVE;
               end
            end
            default: bus_q <= ccds_pkg::CCDS_BUS_ACTIVE;
         endcase
      end
   end
   assign can_enable = (bus_q == ccds_pkg::CCDS_BUS_ACTIVE) && !bus_off;

   // Receive byte pending tracker
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_pending_q <= 1'b0;
      end else if (rx_byte_valid) begin
         rx_pending_q <= 1'b1;
      end else if (rx_byte_read) begin
         rx_pending_q <= 1'b0;
      end
   end

   // Configuration mismatch in sample mode held until resend
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mismatch_q <= 1'b0;
      end else if (cfg_mismatch && is_mode(mode_q, ccds_pkg::CCDS_MODE_SAMPLE)) begin
         mismatch_q <= 1'b1;
      end else if (cfg_resent) begin
         mismatch_q <= 1'b0;
      end
   end

   // Idle time without a valid packet with a valid header
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idle_cnt_q <= '0;
      end else if (rx_msg_valid && rx_header_ok) begin
         idle_cnt_q <= '0;
      end else if (idle_cnt_q < nodata_limit_q) begin
         idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
      end
   end
   assign nodata = idle_cnt_q >= nodata_limit_q;

   // Last status code reported by a remote module in sample mode, once per resume
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_status_q <= '0;
         status_new_q <= 1'b0;
      end else if (remote_status_valid && is_mode(mode_q, ccds_pkg::CCDS_MODE_SAMPLE)) begin
         last_status_q <= remote_status;
         status_new_q <= 1'b1;
      end else if (rd_ok && s_axi_araddr == `CCDS_A_STATUS) begin
         status_new_q <= 1'b0;
      end
   end

   // Per-cycle error events, one bit per code
   always_comb begin
      ev = '0;
      ev[`CCDS_B_FRAMING] = rx_msg_valid && ((rx_len_bad
         && is_mode(mode_q, ccds_pkg::CCDS_MODE_EXPANDER))
         || (rx_sample_count_bad && is_mode(mode_q, ccds_pkg::CCDS_MODE_SAMPLE)));
      ev[`CCDS_B_OVERRUN] = (rx_byte_valid && rx_pending_q && !rx_byte_read)
         || (tx_request && tx_buf_full);
      ev[`CCDS_B_BADCFG] = cfg_overlap || mismatch_q
         || (cfg_mismatch && is_mode(mode_q, ccds_pkg::CCDS_MODE_SAMPLE));
      ev[`CCDS_B_NODATA] = nodata;
      ev[`CCDS_B_CHECKSUM] = rx_msg_valid && rx_header_ok && rx_checksum_bad
         && is_mode(mode_q, ccds_pkg::CCDS_MODE_GENERAL);
      ev[`CCDS_B_WRONG] = rx_msg_valid && ((rx_decode_bad
         && is_mode(mode_q, ccds_pkg::CCDS_MODE_GENERAL))
         || (rx_id_bad && is_mode(mode_q, ccds_pkg::CCDS_MODE_EXPANDER))
         || (rx_len_bad && is_mode(mode_q, ccds_pkg::CCDS_MODE_SAMPLE)));
      ev[`CCDS_B_WARN] = warn;
      ev[`CCDS_B_BUSOFF] = bus_off || bus_q == ccds_pkg::CCDS_BUS_OFF;
      ev[`CCDS_B_TXWARN] = ctrl_tx_warn;
   end

   // Sticky word; a new event wins over a clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sticky_q <= '0;
      end else begin
         sticky_q <= (sticky_q & ~clr_mask) | ev;
      end
   end

   // Diagnostic word: each code its own bit, so sum equals OR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         diag_word_q <= '0;
      end else begin
         diag_word_q <= (sticky_q & ~clr_mask) | ev;
      end
   end

   // AXI4-Lite write channel capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_q <= 1'b0;
         w_data_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_q <= 1'b1;
         w_data_q <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
      end else if (wr_fire) begin
         w_have_q <= 1'b0;
      end
   end

   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready = !w_have_q && !s_axi_bvalid;
   assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
   assign recover = wr_fire && aw_addr_q == `CCDS_A_CTRL && w_data_q[1];
   assign clr_mask = (wr_fire && aw_addr_q == `CCDS_A_CLEAR)
      ? w_data_q[`CCDS_DIAG_W-1:0] : '0;

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CCDS_RESP_OK;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= mapped(aw_addr_q) ? `CCDS_RESP_OK : `CCDS_RESP_ERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Writable control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q <= ccds_pkg::CCDS_MODE_GENERAL;
         nodata_limit_q <= NODATA_CYCLES;
      end else if (wr_fire && aw_addr_q == `CCDS_A_CFG) begin
         case (w_data_q[2:0])
            3'b001: mode_q <= ccds_pkg::CCDS_MODE_GENERAL;
            3'b010: mode_q <= ccds_pkg::CCDS_MODE_EXPANDER;
            3'b100: mode_q <= ccds_pkg::CCDS_MODE_SAMPLE;
            default: mode_q <= mode_q;
         endcase
      end else if (wr_fire && aw_addr_q == `CCDS_A_WNDW) begin
         nodata_limit_q <= w_data_q;
      end
   end

   // Read data
   always_comb begin
      rd_val = 32'h0000_0000;
      case (s_axi_araddr)
         `CCDS_A_DIAG: rd_val = {16'h0000, diag_word_q};
         `CCDS_A_CTRL: rd_val = {30'h0000_0000, 1'b0, can_enable};
         `CCDS_A_ERRCNT: rd_val = {23'h00_0000, err_cnt};
         `CCDS_A_STATUS: rd_val = {15'h0000, status_new_q, last_status_q};
         `CCDS_A_CFG: rd_val = {29'h0000_0000, mode_q};
         `CCDS_A_WNDW: rd_val = nodata_limit_q;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;
   assign rd_ok = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `CCDS_RESP_OK;
      end else if (rd_ok) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= mapped(s_axi_araddr) ? `CCDS_RESP_OK : `CCDS_RESP_ERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : ccds_diag

// ---- ccds_diag_properties.sv ----
// Port assertions for the CAN diagnostic block
`timescale 1ns/1ps
`include "ccds_consts.svh"
module ccds_diag_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic rx_byte_valid,
   input wire logic rx_byte_read,
   input wire logic tx_request,
   input wire logic tx_buf_full,
   input wire logic cfg_overlap,
   input wire logic ctrl_tx_warn,
   input wire logic can_enable,
   input wire logic [`CCDS_DIAG_W-1:0] diag_word_q
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic pend_q;
   // Unread receive byte
   always_ff @(posedge aclk) begin
      if (!aresetn) pend_q <= 1'b0;
      else if (rx_byte_valid) pend_q <= 1'b1;
      else if (rx_byte_read) pend_q <= 1'b0;
   end
   property p_ovr_rx;
      rx_byte_valid && pend_q && !rx_byte_read |=> diag_word_q[3];
   endproperty
   property p_ovr_tx;
      tx_request && tx_buf_full |=> diag_word_q[3];
   endproperty
   property p_cfg;
      cfg_overlap |=> diag_word_q[8];
   endproperty
   property p_txw;
      ctrl_tx_warn |=> diag_word_q[14];
   endproperty
   property p_off;
      !can_enable |=> diag_word_q[13];
   endproperty
   property p_sum;
      (diag_word_q & 16'h80F5) == 16'h0000;
   endproperty
   property p_bv;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   property p_rv;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   property p_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   property p_nord;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ovr_rx: assert property (p_ovr_rx) else $error("rx overrun missed");
   a_ovr_tx: assert property (p_ovr_tx) else $error("tx overrun missed");
   a_cfg: assert property (p_cfg) else $error("bad config missed");
   a_txw: assert property (p_txw) else $error("tx warning missed");
   a_off: assert property (p_off) else $error("bus off missed");
   a_sum: assert property (p_sum) else $error("stray diag bit");
   a_bv: assert property (p_bv) else $error("late write response");
   a_rv: assert property (p_rv) else $error("late read response");
   a_hold: assert property (p_hold) else $error("bvalid dropped");
   a_nord: assert property (p_nord) else $error("read taken while busy");
   c_off: cover property (!can_enable);
   c_ovr: cover property (diag_word_q[3]);
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule : ccds_diag_properties
bind ccds_diag ccds_diag_properties i_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .rx_byte_valid, .rx_byte_read, .tx_request, .tx_buf_full,
   .cfg_overlap, .ctrl_tx_warn, .can_enable, .diag_word_q);

// ---- ccds_err_counter.sv ----
// Bus error counter with warning and bus off thresholds
`timescale 1ns/1ps
`include "ccds_consts.svh"
module ccds_err_counter #(
   parameter int CNT_W = 9
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic bus_err,
   input wire logic recover,
   output logic [CNT_W-1:0] count_q,
   output logic warn,
   output logic bus_off
);
   always_ff @(posedge aclk) begin
      if (!aresetn || recover) begin
         count_q <= '0;
      end else if (bus_err && count_q <= `CCDS_OFF_LIMIT) begin
         count_q <= count_q + 1'b1;
      end
   end
   assign warn = count_q > `CCDS_WARN_LIMIT;
   assign bus_off = count_q > `CCDS_OFF_LIMIT;
endmodule : ccds_err_counter

// ---- ccds_pkg.sv ----
// Types for the CAN communications diagnostic block
package ccds_pkg;
   typedef enum logic [2:0] {
      CCDS_MODE_GENERAL = 3'b001,
      CCDS_MODE_EXPANDER = 3'b010,
      CCDS_MODE_SAMPLE = 3'b100
   } ccds_mode_t;
   typedef enum logic [1:0] {
      CCDS_BUS_ACTIVE = 2'b01,
      CCDS_BUS_OFF = 2'b10
   } ccds_bus_t;
endpackage : ccds_pkg

// ---- ccds_remote_node.sv ----
// Remote acquisition module status sender
`timescale 1ns/1ps
module ccds_remote_node (
   input wire logic aclk,
   input wire logic resume,
   input wire logic [15:0] reason,
   output logic remote_status_valid,
   output logic [15:0] remote_status
);
   initial remote_status_valid = 1'b0;
   initial remote_status = 16'h0000;
   // One code per resume, line toggles when idle
   always @(posedge aclk) begin
      remote_status_valid <= resume;
      remote_status <= resume ? reason : ~remote_status;
   end
endmodule : ccds_remote_node
